// ==== hdl/vfcu_pkg.sv ====
`default_nettype none
package vfcu_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          VFCU_ADDR_W    = 8;
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_COUNT      = 8'h08;
  localparam int          CTRL_EN_BIT    = 0;
  localparam logic        CTRL_EN_RESET  = 1'b1;
  localparam int          STAT_INDEF_BIT = 0;
  localparam int          STAT_MZERO_BIT = 1;

  // ---------------------------------------------------------------
  // Element formats
  // ---------------------------------------------------------------
  localparam int          DF_INDEF_BIT   = 46;
  localparam int          DF_MZERO_BIT   = 43;
  localparam logic [3:0]  INDEF_NIB      = 4'h7;
  localparam logic [3:0]  MZERO_NIB      = 4'h8;
  localparam logic [15:0] INDEF_EXP64    = 16'h7000;
  localparam logic [15:0] MZERO_EXP64    = 16'h8000;
  localparam logic [7:0]  INDEF_EXP32    = 8'h70;
  localparam logic [7:0]  WIDEN_BIAS     = 8'h18;
  localparam logic [15:0] MAX_SHIFT      = 16'h0030;

  typedef enum logic [2:0] {
    VFCU_OP_FLOOR,
    VFCU_OP_CEIL,
    VFCU_OP_TRUNC,
    VFCU_OP_EXPX,
    VFCU_OP_PACK,
    VFCU_OP_WIDEN
  } vfcu_op_e;

  typedef struct packed {
    logic        valid;
    vfcu_op_e    op;
    logic        half;
    logic [63:0] a;
    logic [63:0] b;
  } vfcu_req_s;

  typedef struct packed {
    logic        valid;
    logic [63:0] data;
    logic [63:0] flags;
  } vfcu_res_s;

  typedef struct packed {
    logic [15:0] exp;
    logic [48:0] coef;
  } vfcu_fp_s;

endpackage

`default_nettype wire

// ==== hdl/vfcu_core.sv ====
// How it works
// - floor gives largest integer not above source, exponent nonnegative.
// - floor, negative exponent: arithmetic right shift to zero exponent.
// - floor and ceiling pass the source when exponent is nonnegative.
// - floor of an all-zero element gives all zeros.
// - ceiling shifts the negated coefficient, negates back, zero exponent.
// - ceiling of machine zero gives all zero bits.
// - floor, ceiling, truncate only report the indefinite flag, bit 46.
// - extract puts sign-extended exponent in coefficient, clears exponent.
// - truncate rounds toward zero; nonnegative exponent passes through.
// - truncate shifts magnitude with zero fill, then restores sign.
// - truncate of a zero element gives zero.
// - pack joins the low bits of A, as exponent, with low coefficient of B.
// - widen lowers the exponent by twenty-four.
// - widen moves 24 coefficient bits up and clears the low 24.
// - widen sign-extends the adjusted 8-bit exponent to 16 bits.
// - widen of indefinite gives indefinite and flag 46.
// - widen of machine zero gives machine zero and flag 43.
// - half mode selects 32-bit operands, otherwise 64-bit; widen always reads a 32-bit source.
// - 64-bit element: high 16 bits exponent, low 48 coefficient.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module vfcu_core (
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   clk_en_i,
  input  wire vfcu_pkg::vfcu_req_s    req_i,
  output var  vfcu_pkg::vfcu_res_s    res_o,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output var  logic [31:0]            reg_rdata_o
);
  import vfcu_pkg::*;

  // ---------------------------------------------------------------
  // Element helpers
  // ---------------------------------------------------------------
  // Bit 0 of the element is the top bit of the vector, so the
  // exponent sits in the high bits and the coefficient below it.
  function automatic vfcu_fp_s unpack(input logic [63:0] v,
                                      input logic        half);
    vfcu_fp_s f;
    if (half) begin
      f.exp  = {{8{v[31]}}, v[31:24]};
      f.coef = {{25{v[23]}}, v[23:0]};
    end else begin
      f.exp  = v[63:48];
      f.coef = {v[47], v[47:0]};
    end
    return f;
  endfunction

  function automatic logic [63:0] repack(input logic [15:0] e,
                                         input logic [48:0] c,
                                         input logic        half);
    if (half) begin
      return {32'h0000_0000, e[7:0], c[23:0]};
    end
    return {e, c[47:0]};
  endfunction

  function automatic logic is_class(input logic [63:0] v,
                                    input logic        half,
                                    input logic [3:0]  nib);
    return half ? (v[31:28] == nib) : (v[63:60] == nib);
  endfunction

  // ---------------------------------------------------------------
  // Control and status state
  // ---------------------------------------------------------------
  logic        ctrl_en;
  logic        stat_indef;
  logic        stat_mzero;
  logic [31:0] elem_count;
  logic        chk_take;

  wire take_w = clk_en_i & req_i.valid & ctrl_en;
  wire half_w = req_i.half;

  // ---------------------------------------------------------------
  // Operand decode
  // ---------------------------------------------------------------
  vfcu_fp_s src_w;
  assign src_w = unpack(req_i.a, half_w);

  wire cls_indef_w = is_class(req_i.a, half_w, INDEF_NIB);
  wire cls_mzero_w = is_class(req_i.a, half_w, MZERO_NIB);
  wire exp_neg_w   = src_w.exp[15];

  wire [15:0] neg_exp_w = 16'(-src_w.exp);
  wire [5:0]  shamt_w   = (neg_exp_w > MAX_SHIFT) ?
                          MAX_SHIFT[5:0] : neg_exp_w[5:0];

  // ---------------------------------------------------------------
  // Floor, ceiling and truncate
  // ---------------------------------------------------------------
  // The coefficient is carried one bit wider than stored so that
  // negating the most negative value cannot wrap.
  wire signed [48:0] coef_s = signed'(src_w.coef);
  wire signed [48:0] ceil_n = 49'(-coef_s);
  wire               c_neg  = src_w.coef[48];
  wire        [48:0] mag_w  = c_neg ? 49'(-coef_s) : src_w.coef;

  wire [48:0] floor_c = 49'(coef_s >>> shamt_w);
  wire [48:0] ceil_sh = 49'(ceil_n >>> shamt_w);
  wire [48:0] ceil_c  = 49'(-signed'(ceil_sh));
  wire [48:0] trunc_m = mag_w >> shamt_w;
  wire [48:0] trunc_c = c_neg ? 49'(-trunc_m) : trunc_m;

  logic [48:0] int_c;
  always_comb begin
    case (req_i.op)
      VFCU_OP_CEIL:  int_c = ceil_c;
      VFCU_OP_TRUNC: int_c = trunc_c;
      default:       int_c = floor_c;
    endcase
  end

  // A nonnegative exponent already names an integer.
  wire [63:0] int_res_w = exp_neg_w ?
                          repack(16'h0000, int_c, half_w) :
                          req_i.a;

  wire [63:0] indef_w = half_w ?
                        {32'h0000_0000, INDEF_EXP32, 24'h00_0000} :
                        {INDEF_EXP64, 48'h0000_0000_0000};

  // ---------------------------------------------------------------
  // Exponent extract, pack and widen
  // ---------------------------------------------------------------
  wire [63:0] expx_w = repack(16'h0000,
                              {{33{src_w.exp[15]}}, src_w.exp},
                              half_w);

  wire [63:0] pack_w = half_w ?
                       {32'h0000_0000, req_i.a[7:0],
                        req_i.b[23:0]} :
                       {req_i.a[15:0], req_i.b[47:0]};

  // Widen always reads a 32-bit source, whatever the mode bit says.
  wire       w_indef = is_class(req_i.a, 1'b1, INDEF_NIB);
  wire       w_mzero = is_class(req_i.a, 1'b1, MZERO_NIB);
  wire [7:0] w_exp   = req_i.a[31:24] - WIDEN_BIAS;

  wire [63:0] widen_w =
    w_indef ? {INDEF_EXP64, 48'h0000_0000_0000} :
    w_mzero ? {MZERO_EXP64, 48'h0000_0000_0000} :
    {{8{w_exp[7]}}, w_exp,
     req_i.a[23:0], 24'h00_0000};

  // ---------------------------------------------------------------
  // Result select
  // ---------------------------------------------------------------
  wire is_round = (req_i.op == VFCU_OP_FLOOR) |
                  (req_i.op == VFCU_OP_CEIL) |
                  (req_i.op == VFCU_OP_TRUNC);

  logic [63:0] next_data;
  logic        out_indef;
  logic        out_mzero;
  always_comb begin
    out_indef = 1'b0;
    out_mzero = 1'b0;
    case (req_i.op)
      VFCU_OP_FLOOR,
      VFCU_OP_CEIL,
      VFCU_OP_TRUNC: begin
        if (cls_indef_w) begin
          next_data = indef_w;
          out_indef = 1'b1;
        end else if (cls_mzero_w) begin
          next_data = 64'h0000_0000_0000_0000;
        end else begin
          next_data = int_res_w;
        end
      end
      VFCU_OP_EXPX:  next_data = expx_w;
      VFCU_OP_PACK:  next_data = pack_w;
      VFCU_OP_WIDEN: begin
        next_data = widen_w;
        out_indef = w_indef;
        out_mzero = w_mzero & ~w_indef;
      end
      default:       next_data = 64'h0000_0000_0000_0000;
    endcase
  end

  logic [63:0] next_flags;
  always_comb begin
    next_flags = 64'h0000_0000_0000_0000;
    next_flags[DF_INDEF_BIT] = out_indef;
    next_flags[DF_MZERO_BIT] = out_mzero;
  end

  // ---------------------------------------------------------------
  // Result register
  // ---------------------------------------------------------------
  // One element per cycle with no stall: the stream side must be
  // ready to store every result it asked for.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res_o <= '0;
    end else if (clk_en_i) begin
      res_o.valid <= take_w;
      if (take_w) begin
        res_o.data  <= next_data;
        res_o.flags <= next_flags;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  wire wr_ctrl   = reg_wr_i & (reg_addr_i == REG_CTRL);
  wire wr_status = reg_wr_i & (reg_addr_i == REG_STATUS);
  wire wr_count  = reg_wr_i & (reg_addr_i == REG_COUNT);
  wire ev_indef  = take_w & out_indef;
  wire ev_mzero  = take_w & out_mzero;
  wire clr_indef = wr_status & reg_wdata_i[STAT_INDEF_BIT];
  wire clr_mzero = wr_status & reg_wdata_i[STAT_MZERO_BIT];

  // A new event in the clearing cycle keeps its status bit set.
  wire next_indef = (stat_indef & ~clr_indef) | ev_indef;
  wire next_mzero = (stat_mzero & ~clr_mzero) | ev_mzero;

  wire [31:0] next_count = wr_count ? reg_wdata_i :
                           elem_count + {31'h0000_0000, take_w};

  wire [31:0] rd_mux =
    (reg_addr_i == REG_CTRL)   ? {31'h0000_0000, ctrl_en} :
    (reg_addr_i == REG_STATUS) ? {30'h0000_0000, stat_mzero,
                                  stat_indef} :
    (reg_addr_i == REG_COUNT)  ? elem_count :
                                 32'h0000_0000;

  wire [31:0] next_rdata = reg_rd_i ? rd_mux : 32'h0000_0000;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_en     <= CTRL_EN_RESET;
      stat_indef  <= 1'b0;
      stat_mzero  <= 1'b0;
      elem_count  <= 32'h0000_0000;
      reg_rdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        ctrl_en <= reg_wdata_i[CTRL_EN_BIT];
      end
      stat_indef  <= next_indef;
      stat_mzero  <= next_mzero;
      elem_count  <= next_count;
      reg_rdata_o <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chk_take <= 1'b0;
    end else begin
      chk_take <= take_w;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_floor_pass: assert property (
    chk_take && $past(req_i.op) == VFCU_OP_FLOOR &&
    !$past(exp_neg_w) && !$past(cls_indef_w) |->
    res_o.data == $past(req_i.a))
    else $error("floor did not pass element through");

  a_floor_sign: assert property (
    chk_take && $past(req_i.op) == VFCU_OP_FLOOR &&
    !$past(half_w) && $past(exp_neg_w) &&
    !$past(cls_mzero_w) |->
    res_o.data[63:48] == 16'h0000 &&
    res_o.data[47] == $past(req_i.a[47]))
    else $error("floor shift lost sign or exponent");

  a_ceil_pos: assert property (
    chk_take && $past(req_i.op) == VFCU_OP_CEIL &&
    !$past(half_w) && $past(exp_neg_w) &&
    !$past(cls_mzero_w) && !$past(req_i.a[47]) &&
    $past(req_i.a[47:0]) != 48'h0000_0000_0000 |->
    res_o.data[63:48] == 16'h0000 && !res_o.data[47] &&
    res_o.data[47:0] != 48'h0000_0000_0000)
    else $error("ceiling of positive fraction not positive");

  a_trunc_mag: assert property (
    chk_take && $past(req_i.op) == VFCU_OP_TRUNC &&
    !$past(half_w) && $past(exp_neg_w) &&
    !$past(cls_mzero_w) && !$past(req_i.a[47]) |->
    res_o.data[47:0] <= $past(req_i.a[47:0]))
    else $error("truncate grew magnitude");

  a_zero_elem: assert property (
    chk_take && $past(is_round) &&
    ($past(req_i.a) == 64'h0000_0000_0000_0000 ||
     $past(cls_mzero_w)) |->
    res_o.data == 64'h0000_0000_0000_0000)
    else $error("zero source gave nonzero result");

  a_round_flags: assert property (
    chk_take && $past(is_round) |->
    !res_o.flags[DF_MZERO_BIT] &&
    res_o.flags[DF_INDEF_BIT] == $past(cls_indef_w))
    else $error("wrong flag on rounding operation");

  a_expx_field: assert property (
    chk_take && $past(req_i.op) == VFCU_OP_EXPX &&
    !$past(half_w) |->
    res_o.data == {16'h0000, {32{$past(req_i.a[63])}},
                   $past(req_i.a[63:48])})
    else $error("exponent extract misplaced");

  a_pack_build: assert property (
    chk_take && $past(req_i.op) == VFCU_OP_PACK &&
    !$past(half_w) |->
    res_o.data == {$past(req_i.a[15:0]), $past(req_i.b[47:0])})
    else $error("pack result wrong");

  a_widen_form: assert property (
    chk_take && $past(req_i.op) == VFCU_OP_WIDEN &&
    !$past(w_indef) && !$past(w_mzero) |->
    res_o.data[55:48] == 8'($past(req_i.a[31:24]) - 8'h18) &&
    res_o.data[63:56] == {8{res_o.data[55]}} &&
    res_o.data[47:24] == $past(req_i.a[23:0]) &&
    res_o.data[23:0] == 24'h00_0000)
    else $error("widen result malformed");

  a_widen_spec: assert property (
    chk_take && $past(req_i.op) == VFCU_OP_WIDEN &&
    ($past(w_indef) || $past(w_mzero)) |->
    res_o.flags[DF_INDEF_BIT] == $past(w_indef) &&
    res_o.flags[DF_MZERO_BIT] == !$past(w_indef) &&
    res_o.data[47:0] == 48'h0000_0000_0000)
    else $error("widen special case wrong");

  a_valid_time: assert property (
    clk_en_i |=> res_o.valid == $past(take_w))
    else $error("result valid out of step");

endmodule

`default_nettype wire

// ==== tb/vfcu_stream_sink.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Result store side of the vector stream
// ------------------------------------------------------------
module vfcu_stream_sink (
  input wire logic                sys_clk_i,
  input wire logic                reset_n_i,
  input wire logic                clk_en_i,
  input wire vfcu_pkg::vfcu_res_s res_i
);
  import vfcu_pkg::*;
  logic [127:0] got_q[$];
  // A valid frozen by a low enable is still one element.
  always @(posedge sys_clk_i) begin
    if (reset_n_i && clk_en_i && res_i.valid) begin
      got_q.push_back({res_i.data, res_i.flags});
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import vfcu_pkg::*;
  logic         sys_clk;
  logic         reset_n;
  logic         clk_en;
  logic         reg_wr;
  logic         reg_rd;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic [31:0]  reg_rdata;
  vfcu_req_s    req;
  vfcu_res_s    res;
  logic [127:0] exp_q[$];
  int           n_mismatch;
  int           total_checks;
  bit           accept;
  logic [63:0]  spec [5] = '{64'h0, 64'h8000_0000_0000_0000,
    64'h7000_0000_0000_0000, 64'h0000_0000_FD00_0005,
    64'h0000_0000_FDFF_FFFB};

  vfcu_core u_dut (
    .sys_clk_i   (sys_clk),
    .reset_n_i   (reset_n),
    .clk_en_i    (clk_en),
    .req_i       (req),
    .res_o       (res),
    .reg_addr_i  (reg_addr),
    .reg_wdata_i (reg_wdata),
    .reg_wr_i    (reg_wr),
    .reg_rd_i    (reg_rd),
    .reg_rdata_o (reg_rdata)
  );
  vfcu_stream_sink u_sink (
    .sys_clk_i (sys_clk),
    .reset_n_i (reset_n),
    .clk_en_i  (clk_en),
    .res_i     (res)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Reference model and bus tasks
  // ------------------------------------------------------------
  function automatic void ref_calc(input int op, input bit h,
      input logic [63:0] a, input logic [63:0] b,
      output logic [63:0] d, output logic [63:0] f);
    longint     e;
    longint     c;
    int         n;
    logic [3:0] top;
    logic [7:0] x;
    e = h ? longint'($signed(a[31:24])) : longint'($signed(a[63:48]));
    c = h ? longint'($signed(a[23:0])) : longint'($signed(a[47:0]));
    top = h ? a[31:28] : a[63:60];
    d = 64'h0;
    f = 64'h0;
    n = (-e > 48) ? 48 : int'(-e);
    if (op < 3) begin
      if (top == INDEF_NIB) begin
        d = h ? {32'h0, 8'h70, 24'h0} : {16'h7000, 48'h0};
        f[46] = 1'b1;
      end else if (top == MZERO_NIB) begin
        d = 64'h0;
      end else if (e >= 0) begin
        d = a;
      end else begin
        if (op == 0) c = c >>> n;
        else if (op == 1) c = -((-c) >>> n);
        else c = (c < 0) ? -((-c) >> n) : c >> n;
        d = h ? {40'h0, c[23:0]} : {16'h0, c[47:0]};
      end
    end else if (op == 3) begin
      d = h ? {40'h0, e[23:0]} : {16'h0, e[47:0]};
    end else if (op == 4) begin
      d = h ? {32'h0, a[7:0], b[23:0]} : {a[15:0], b[47:0]};
    end else if (a[31:28] == INDEF_NIB) begin
      d = {16'h7000, 48'h0};
      f[46] = 1'b1;
    end else if (a[31:28] == MZERO_NIB) begin
      d = {16'h8000, 48'h0};
      f[43] = 1'b1;
    end else begin
      x = a[31:24] - 8'h18;
      d = {{8{x[7]}}, x, a[23:0], 24'h0};
    end
  endfunction

  task automatic chk(input logic [127:0] e, input logic [127:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic reg_write(input logic [7:0] ad, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [7:0] ad, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({96'h0, v}, {96'h0, reg_rdata});
  endtask

  task automatic push(input int op, input bit h, input logic [63:0] a,
      input logic [63:0] b);
    logic [63:0] d;
    logic [63:0] f;
    ref_calc(op, h, a, b, d, f);
    if (accept) exp_q.push_back({d, f});
    @(posedge sys_clk);
    req <= {1'b1, vfcu_op_e'(op[2:0]), h, a, b};
  endtask

  task automatic rnd(input int op, input bit h, input int k);
    logic [63:0] a;
    logic [63:0] b;
    int          e;
    repeat (k) begin
      e = int'($urandom_range(60)) - 52;
      b = (op == 4) ? {$urandom, $urandom} : 64'h0;
      if (h) b[63:32] = 32'h0;
      if (h) a = {32'h0, 8'(e), 24'($urandom)};
      else a = {16'(e), 16'($urandom), $urandom};
      push(op, h, a, b);
    end
  endtask

  task automatic flush;
    @(posedge sys_clk);
    req.valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(128'(exp_q.size()), 128'(u_sink.got_q.size()));
    while (exp_q.size() > 0 && u_sink.got_q.size() > 0) begin
      chk(exp_q.pop_front(), u_sink.got_q.pop_front());
    end
    exp_q.delete();
    u_sink.got_q.delete();
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    req = '0;
    accept = 1'b1;
    void'($urandom(11));
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    reg_check(REG_CTRL, 32'h0000_0001);
    reg_check(8'h0C, 32'h0000_0000);
    $display("test registers done");
    for (int op = 0; op < 3; op++) begin
      for (int i = 0; i < 5; i++) push(op, i > 2, spec[i], 64'h0);
    end
    push(5, 1'b1, 64'h0000_0000_7000_0000, 64'h0);
    push(5, 1'b1, 64'h0000_0000_8000_0000, 64'h0);
    push(5, 1'b1, 64'h0000_0000_4F12_3456, 64'h0);
    flush();
    $display("test directed done");
    for (int op = 0; op < 6; op++) begin
      rnd(op, 1'b0, 12);
      rnd(op, 1'b1, 12);
    end
    flush();
    $display("test random done");
    reg_check(REG_STATUS, 32'h0000_0003);
    reg_write(REG_STATUS, 32'h0000_0003);
    reg_check(REG_STATUS, 32'h0000_0000);
    reg_write(REG_COUNT, 32'h0000_0000);
    rnd(0, 1'b0, 5);
    flush();
    reg_check(REG_COUNT, 32'h0000_0005);
    $display("test status and count done");
    // Disabled stream and frozen clock must both drop elements.
    reg_write(REG_CTRL, 32'h0000_0000);
    accept = 1'b0;
    rnd(1, 1'b0, 3);
    flush();
    reg_write(REG_CTRL, 32'h0000_0001);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    rnd(2, 1'b1, 2);
    flush();
    @(posedge sys_clk);
    clk_en <= 1'b1;
    accept = 1'b1;
    reg_check(REG_COUNT, 32'h0000_0005);
    $display("test refusal done");
    conclude();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
